//--- pkg/aor_consts.svh
`ifndef AOR_CONSTS_SVH
`define AOR_CONSTS_SVH
// ----------------------------------------
// Converter constants
// ----------------------------------------
`define AOR_DATA_W      12
`define AOR_LATENCY     6
`define AOR_REF_W       2
// Reference select strap codes
`define AOR_SEL_TO_REF  2'h0
`define AOR_SEL_TO_GND  2'h1
`define AOR_SEL_TO_VS   2'h2
// Reference output codes
`define AOR_REF_OFF     2'h0
`define AOR_REF_1V      2'h1
`define AOR_REF_2V5     2'h2
`define AOR_BUF_DEPTH   2
`endif

//--- pkg/aor_pkg.sv
package aor_pkg;
  typedef enum logic [2:0] {
    AOR_REF_INT_SMALL = 3'h1,
    AOR_REF_INT_LARGE = 3'h2,
    AOR_REF_EXTERNAL  = 3'h4
  } aor_ref_mode_e;
endpackage

//--- hdl/aor_skid_buf.sv
`timescale 1ns/1ns
`include "aor_consts.svh"
module aor_skid_buf #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] s_data_in,
  input  wire logic             s_valid_in,
  output logic                  s_ready_out,
  output logic      [WIDTH-1:0] m_data_out,
  output logic                  m_valid_out,
  input  wire logic             m_ready_in
);
  // ----------------------------------------
  // Two-entry buffer
  // ----------------------------------------
  logic [WIDTH-1:0] mem_ff [`AOR_BUF_DEPTH];
  logic             rd_ptr_ff;
  logic             wr_ptr_ff;
  logic [1:0]       count_ff;
  logic             push;
  logic             pop;

  assign s_ready_out = (count_ff != 2'(`AOR_BUF_DEPTH));
  assign m_valid_out = (count_ff != 2'h0);
  assign m_data_out  = mem_ff[rd_ptr_ff];
  assign push        = s_valid_in && s_ready_out;
  assign pop         = m_valid_out && m_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= s_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end
endmodule // aor_skid_buf

//--- hdl/aor_readout.sv
`timescale 1ns/1ns
`include "aor_consts.svh"
module aor_readout #(
  parameter int DATA_W  = `AOR_DATA_W,
  parameter int LATENCY = `AOR_LATENCY
) (
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_N_IN,
  input  wire logic [DATA_W-1:0]       SAMPLE_IN,
  input  wire logic                    ABOVE_TOP_IN,
  input  wire logic                    BELOW_BOTTOM_IN,
  input  wire logic [1:0]              REF_SEL_IN,
  input  wire logic                    DATA_READY_IN,
  output logic      [DATA_W-1:0]       DATA_OUT,
  output logic                         OUT_OF_RANGE_FLAG_OUT,
  output logic                         DATA_VALID_OUT,
  output logic                         SAMPLE_LOST_OUT,
  output logic      [`AOR_REF_W-1:0]   REF_LEVEL_OUT,
  output logic                         REF_DRIVE_N_OUT
);
  // ----------------------------------------
  // Reference strap
  // ----------------------------------------
  aor_pkg::aor_ref_mode_e ref_mode_ff;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ref_mode_ff <= aor_pkg::AOR_REF_INT_SMALL;
    end else begin
      case (REF_SEL_IN)
        `AOR_SEL_TO_GND: ref_mode_ff <= aor_pkg::AOR_REF_INT_LARGE;
        `AOR_SEL_TO_VS:  ref_mode_ff <= aor_pkg::AOR_REF_EXTERNAL;
        default:         ref_mode_ff <= aor_pkg::AOR_REF_INT_SMALL;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      REF_LEVEL_OUT   <= `AOR_REF_1V;
      REF_DRIVE_N_OUT <= 1'b0;
    end else begin
      unique case (ref_mode_ff)
        aor_pkg::AOR_REF_INT_SMALL: begin
          REF_LEVEL_OUT   <= `AOR_REF_1V;
          REF_DRIVE_N_OUT <= 1'b0;
        end
        aor_pkg::AOR_REF_INT_LARGE: begin
          REF_LEVEL_OUT   <= `AOR_REF_2V5;
          REF_DRIVE_N_OUT <= 1'b0;
        end
        aor_pkg::AOR_REF_EXTERNAL: begin
          REF_LEVEL_OUT   <= `AOR_REF_OFF;
          REF_DRIVE_N_OUT <= 1'b1;
        end
        default: begin
          REF_LEVEL_OUT   <= `AOR_REF_OFF;
          REF_DRIVE_N_OUT <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Sample pipeline
  // ----------------------------------------
  // Flag rides in the same word as data, so latency cannot drift apart
  logic [DATA_W:0] pipe_ff [LATENCY];
  logic            range_bad;

  assign range_bad = ABOVE_TOP_IN || BELOW_BOTTOM_IN;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pipe_ff[0] <= '0;
    end else begin
      pipe_ff[0] <= {range_bad, SAMPLE_IN};
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < LATENCY; gi++) begin : g_pipe
      always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          pipe_ff[gi] <= '0;
        end else begin
          pipe_ff[gi] <= pipe_ff[gi-1];
        end
      end
    end
  endgenerate

  // Pipe fill counter: words are valid only once the pipe holds samples
  logic [7:0] fill_ff;
  logic       pipe_valid;
  assign pipe_valid = (fill_ff == 8'(LATENCY));

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fill_ff <= 8'h00;
    end else if (!pipe_valid) begin
      fill_ff <= fill_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  // Converter cannot stall: a full buffer drops the word and says so
  logic [DATA_W:0] buf_data;
  logic            buf_valid;
  logic            buf_in_ready;

  aor_skid_buf #(
    .WIDTH (DATA_W + 1)
  ) u_buf (
    .clk_in      (CLK_IN),
    .rst_n_in    (RST_N_IN),
    .s_data_in   (pipe_ff[LATENCY-1]),
    .s_valid_in  (pipe_valid),
    .s_ready_out (buf_in_ready),
    .m_data_out  (buf_data),
    .m_valid_out (buf_valid),
    .m_ready_in  (DATA_READY_IN || !DATA_VALID_OUT)
  );

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DATA_OUT              <= '0;
      OUT_OF_RANGE_FLAG_OUT <= 1'b0;
      DATA_VALID_OUT        <= 1'b0;
    end else if (DATA_READY_IN || !DATA_VALID_OUT) begin
      DATA_VALID_OUT <= buf_valid;
      if (buf_valid) begin
        DATA_OUT              <= buf_data[DATA_W-1:0];
        OUT_OF_RANGE_FLAG_OUT <= buf_data[DATA_W];
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SAMPLE_LOST_OUT <= 1'b0;
    end else begin
      SAMPLE_LOST_OUT <= pipe_valid && !buf_in_ready;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_flag_tracks;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    pipe_valid |-> pipe_ff[LATENCY-1][DATA_W] ==
      $past(range_bad, LATENCY);
  endproperty
  a_flag_tracks: assert property (p_flag_tracks)
    else $error("Flag latency differs from data");

  property p_data_tracks;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    pipe_valid |-> pipe_ff[LATENCY-1][DATA_W-1:0] ==
      $past(SAMPLE_IN, LATENCY);
  endproperty
  a_data_tracks: assert property (p_data_tracks)
    else $error("Sample lost in pipeline");

  property p_ext_ref;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    REF_SEL_IN == `AOR_SEL_TO_VS |-> ##2 REF_DRIVE_N_OUT;
  endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("Reference pin not released");

  property p_big_ref;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    REF_SEL_IN == `AOR_SEL_TO_GND |-> ##2 REF_LEVEL_OUT == `AOR_REF_2V5;
  endproperty
  a_big_ref: assert property (p_big_ref)
    else $error("Wrong internal reference level");

  property p_hold_stall;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    DATA_VALID_OUT && !DATA_READY_IN |=> $stable(DATA_OUT) &&
      $stable(OUT_OF_RANGE_FLAG_OUT) && DATA_VALID_OUT;
  endproperty
  a_hold_stall: assert property (p_hold_stall)
    else $error("Output word changed while stalled");

  property p_small_ref;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    REF_SEL_IN == `AOR_SEL_TO_REF |-> ##2
      REF_LEVEL_OUT == `AOR_REF_1V && !REF_DRIVE_N_OUT;
  endproperty
  a_small_ref: assert property (p_small_ref)
    else $error("Wrong small reference level");

  // Buffer pops only when the output register loads, else words repeat
  sequence s_handoff;
    buf_valid && (DATA_READY_IN || !DATA_VALID_OUT);
  endsequence

  sequence s_word_shown;
    DATA_VALID_OUT && DATA_OUT == $past(buf_data[DATA_W-1:0]) &&
      OUT_OF_RANGE_FLAG_OUT == $past(buf_data[DATA_W]);
  endsequence

  property p_out_pair;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_handoff |=> s_word_shown;
  endproperty
  a_out_pair: assert property (p_out_pair)
    else $error("Output word and flag not from one entry");

  property p_lost_pulse;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    pipe_valid && !buf_in_ready |=> SAMPLE_LOST_OUT;
  endproperty
  a_lost_pulse: assert property (p_lost_pulse)
    else $error("Dropped sample not reported");
endmodule // aor_readout

//--- test/aor_capture_model.sv
`timescale 1ns/1ns
module aor_capture_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] data_in,
  input  wire logic        flag_in,
  input  wire logic        valid_in,
  input  wire logic        stall_in,
  input  wire logic        strict_in,
  input  wire logic        drive_n_in,
  output logic             ready_out,
  output logic             ext_ref_out,
  output logic             over_out,
  output logic             under_out,
  output int               n_rx_out,
  output int               n_bad_out
);
  logic [12:0] cap_ff;
  logic [11:0] last_ff;
  logic        bad;
  // Edge flag comes from the low nibble the bench drives
  assign bad = flag_in !== (data_in[3:0] == 4'hF || data_in[3:0] == 4'h0);
  assign ready_out = !stall_in;
  assign ext_ref_out = drive_n_in;
  assign over_out = cap_ff[0] & cap_ff[12];
  assign under_out = cap_ff[0] & !cap_ff[12];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_ff <= '0;
      last_ff <= 12'hFFF;
      n_rx_out <= 0;
      n_bad_out <= 0;
    end else if (valid_in && ready_out) begin
      cap_ff <= {data_in, flag_in};
      last_ff <= data_in;
      n_rx_out <= n_rx_out + 1;
      // Drops allowed only when not strict, order always kept
      if (bad || (strict_in ? data_in !== last_ff + 12'h1
                            : data_in <= last_ff)) begin
        n_bad_out <= n_bad_out + 1;
      end
    end
  end
endmodule // aor_capture_model

//--- test/tb.sv
`timescale 1ns/1ns
`include "aor_consts.svh"
module tb;
  localparam int LAT = `AOR_LATENCY;
  logic clk = 0, rst_n = 0, rdy, valid, lost, drv_n, oor, ext, out_of_range_flag, und;
  logic [11:0] cnt = '0, dout, held;
  logic [1:0]  sel = 2'h0, lvl;
  logic [1:0]  lv[4] = '{`AOR_REF_1V, `AOR_REF_2V5, `AOR_REF_OFF, `AOR_REF_1V};
  logic stall = 0, strict = 1;
  int n_rx, n_bad, mismatches = 0, n_compared = 0, n_lost = 0;
  aor_readout #(.LATENCY(LAT)) aor_readout_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .SAMPLE_IN(cnt),
    .ABOVE_TOP_IN(cnt[3:0] == 4'hF), .BELOW_BOTTOM_IN(cnt[3:0] == 4'h0),
    .REF_SEL_IN(sel), .DATA_READY_IN(rdy), .DATA_OUT(dout),
    .OUT_OF_RANGE_FLAG_OUT(oor), .DATA_VALID_OUT(valid),
    .SAMPLE_LOST_OUT(lost), .REF_LEVEL_OUT(lvl), .REF_DRIVE_N_OUT(drv_n));
  aor_capture_model aor_capture_model_i (
    .clk_in(clk), .rst_n_in(rst_n), .data_in(dout), .flag_in(oor),
    .valid_in(valid), .stall_in(stall), .strict_in(strict),
    .drive_n_in(drv_n), .ready_out(rdy), .ext_ref_out(ext),
    .over_out(out_of_range_flag), .under_out(und), .n_rx_out(n_rx), .n_bad_out(n_bad));
  initial forever #25 clk = ~clk;
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  // Counting samples make order and pairing visible
  always @(negedge clk) cnt <= rst_n ? cnt + 12'h1 : 12'h0;
  always @(posedge clk) if (lost === 1'b1) n_lost++;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rst_n <= 0;
    strict <= 1;
    cyc(20);
    chk(lvl, `AOR_REF_1V);
    chk(drv_n, 0);
    chk(valid, 0);
    rst_n <= 1;
  endtask
  // First word appears a fixed count after the first sample
  task automatic t_latency;
    cyc(LAT + 1);
    chk(valid, 0);
    cyc(1);
    chk(valid, 1);
    chk(dout, 12'h0);
    chk(oor, 1);
    cyc(1);
    chk(dout, 12'h1);
    chk(oor, 0);
    chk(und, 1);
    chk(out_of_range_flag, 0);
    cyc(1);
    chk(und, 0);
    chk(out_of_range_flag, 0);
  endtask
  task automatic t_flow;
    int lost0;
    lost0 = n_lost;
    cyc(64);
    chk(n_bad, 0);
    chk(n_rx > 60, 1);
    chk(n_lost != lost0, 0);
    strict <= 0;
  endtask
  // Stall long enough to overflow the two-entry buffer
  task automatic t_stall;
    stall <= 1;
    cyc(2);
    held = dout;
    cyc(12);
    chk(valid, 1);
    chk(dout, held);
    chk(n_lost != 0, 1);
    stall <= 0;
    for (int i = 0; i < 20 && n_rx < 70; i++) cyc(1);
    if (n_rx < 70) begin
      mismatches++;
      conclude();
    end
    chk(n_bad, 0);
  endtask
  task automatic t_slow;
    for (int i = 0; i < 40; i++) begin
      stall <= i[0];
      cyc(1);
    end
    stall <= 0;
    cyc(12);
    chk(n_bad, 0);
  endtask
  task automatic t_strap;
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      cyc(3);
      chk(lvl, lv[i]);
      chk(drv_n, i == 2);
      chk(ext, i == 2);
    end
    sel <= 2'h0;
  endtask
  // Counting into the top half brings the MSB into play
  task automatic t_range;
    for (int i = 0; i < 2500 && dout !== 12'h80F; i++) cyc(1);
    if (dout !== 12'h80F) begin
      mismatches++;
      conclude();
    end
    cyc(1);
    chk(out_of_range_flag, 1);
    chk(und, 0);
  endtask
  initial begin
    t_reset();
    t_latency();
    t_flow();
    t_stall();
    t_slow();
    t_strap();
    t_range();
    t_reset();
    t_latency();
    t_flow();
    conclude();
  end
endmodule // tb
